// File: core/ico_pkg.sv
/*
  Shared constants and types of the input capture / overflow interrupt block.
  Assumes a single bus clock domain; every file names items as ico_pkg::name.
*/
`default_nettype none
package ico_pkg;
  localparam int NUM_CAP = 3;
  localparam int NUM_SRC = 4;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [3:0] PRE_LIM_1 = 4'h0;
  localparam logic [3:0] PRE_LIM_4 = 4'h3;
  localparam logic [3:0] PRE_LIM_8 = 4'h7;
  localparam logic [3:0] PRE_LIM_16 = 4'hf;
  localparam logic [3:0] MUL_CYCLES = 4'ha;
  localparam logic [3:0] STACK_BYTES = 4'h9;
  localparam logic [15:0] VEC_CAP1 = 16'hffee;
  localparam logic [15:0] VEC_CAP2 = 16'hffec;
  localparam logic [15:0] VEC_CAP3 = 16'hffea;
  localparam logic [15:0] VEC_WRAP = 16'hffde;
  typedef enum logic [4:0] {
    SEQ_RUN = 5'b00001,
    SEQ_STACK = 5'b00010,
    SEQ_VEC_HI = 5'b00100,
    SEQ_VEC_LO = 5'b01000,
    SEQ_JUMP = 5'b10000
  } ico_seq_state_t;
endpackage : ico_pkg
`default_nettype wire

// File: core/ico_insn_if.sv
/*
  Link between the interrupt sequencer and the instruction timer.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface ico_insn_if;
  logic hold;
  logic boundary;
  modport top (input boundary, output hold);
  modport timer (output boundary, input hold);
endinterface : ico_insn_if
`default_nettype wire

// File: core/ico_capture.sv
/*
  One capture channel: pin synchroniser, edge select and capture latch.
  Assumes pin_i is asynchronous and count_i comes from the bus clock domain.
*/
`default_nettype none
module ico_capture (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic [1:0] mode_i,
  input wire logic [15:0] count_i,
  output logic [15:0] value_o,
  output logic event_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [15:0] value;
  } ico_cap_state_t;

  ico_cap_state_t st_q;
  ico_cap_state_t st_d;

  function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = (mode == ico_pkg::EDGE_RISE) || (mode == ico_pkg::EDGE_ANY);
    fall = (mode == ico_pkg::EDGE_FALL) || (mode == ico_pkg::EDGE_ANY);
    edge_hit = (rise && !prev && now) || (fall && prev && !now);
  endfunction : edge_hit

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
    event_o = edge_hit(mode_i, st_q.prev, st_q.s2); // see R2
    // Latch regardless of the flag: the old value is simply overwritten
    if (event_o)
    begin
      st_d.value = count_i; // see R3
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign value_o = st_q.value;

  a_capture_latch: // see R3
  assert property (@(posedge clk_i) disable iff (rst_i) event_o |=> value_o == $past(count_i))
  else $error("capture value does not match counter at edge");

  a_edge_off: // see R2
  assert property (@(posedge clk_i) disable iff (rst_i) mode_i == ico_pkg::EDGE_OFF |-> !event_o)
  else $error("capture event while channel disabled");
endmodule : ico_capture
`default_nettype wire

// File: core/ico_insn_timer.sv
/*
  Instruction length timer: marks the last cycle of each instruction.
  Assumes the core pulses start_i once per instruction with its length.
*/
`default_nettype none
module ico_insn_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] len_i,
  input wire logic multiply_opcode_i,
  ico_insn_if.timer insn_if
);
  typedef struct packed {
    logic busy;
    logic [3:0] left;
  } ico_insn_state_t;

  ico_insn_state_t st_q;
  ico_insn_state_t st_d;
  logic accept;

  assign insn_if.boundary = st_q.busy && (st_q.left == 4'h0);

  always_comb
  begin
    st_d = st_q;
    accept = start_i && !insn_if.hold && (!st_q.busy || insn_if.boundary);
    if (st_q.busy)
    begin
      if (st_q.left != 4'h0)
      begin
        st_d.left = 4'(st_q.left - 4'h1);
      end
      else
      begin
        st_d.busy = 1'b0;
      end
    end
    if (accept)
    begin
      st_d.busy = 1'b1;
      if (multiply_opcode_i)
      begin
        st_d.left = 4'(ico_pkg::MUL_CYCLES - 4'h1); // see R7
      end
      else if (len_i == 4'h0)
      begin
        st_d.left = 4'h0;
      end
      else
      begin
        st_d.left = 4'(len_i - 4'h1);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  a_mul_ten: // see R7
  assert property (@(posedge clk_i) disable iff (rst_i)
    accept && multiply_opcode_i
    |=> (!insn_if.boundary)[*8] ##1 !insn_if.boundary ##1 insn_if.boundary)
  else $error("multiply did not end after ten cycles");
endmodule : ico_insn_timer
`default_nettype wire

// File: core/ico_top.sv
/*
  Free-running 16-bit timer with three input captures, a wrap flag and an
  interrupt sequencer that stacks, resolves priority and fetches the vector.
  Assumes capture pins are asynchronous; all other inputs are on clk_i.
*/
`default_nettype none
// Summary of operation
// R1 - The 16-bit counter runs freely and sets the wrap flag when it rolls over from all ones.
// R2 - Three capture channels each latch the counter on a rising or falling edge of their pin.
// R3 - A qualifying edge always latches the counter even when the channel flag is already set.
// R4 - Interrupt processing starts only at an instruction boundary seen in the last cycle.
// R5 - The vector is chosen only once register stacking has finished.
// R6 - A higher request pending before the flags byte is stacked wins the vector.
// R7 - A multiply instruction lasts ten cycles and any pending interrupt waits for it.
// R8 - Counter wrap ranks below all three capture requests.
// R9 - No new request is taken while a service routine runs, until its return.
// R10 - With prescale one the counter advances once per bus cycle.
// R11 - Software treats a capture with top bit set as before the wrap, clear as after it.
// R12 - On taking an interrupt the start address is read from the vector and jumped to.
// R13 - The first capture vector is the two-byte location holding high and low bytes.
// R14 - Flags clear by writing one to their bit; writing zero leaves them unchanged.
module ico_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] cap_pin_i,
  input wire logic [5:0] cap_mode_i,
  input wire logic [1:0] prescale_sel_i,
  input wire logic flag_clr_we_i,
  input wire logic [3:0] flag_clr_data_i,
  input wire logic [3:0] irq_en_i,
  input wire logic insn_start_i,
  input wire logic [3:0] insn_len_i,
  input wire logic multiply_opcode_i,
  input wire logic rti_i,
  input wire logic [7:0] vec_data_i,
  output logic [15:0] count_o,
  output logic [47:0] cap_value_o,
  output logic [2:0] capture_event_flag_o,
  output logic counter_wrap_flag_o,
  output logic insn_boundary_o,
  output logic cpu_hold_o,
  output logic stack_wr_o,
  output logic stack_cond_flags_o,
  output logic vec_rd_o,
  output logic [15:0] vec_addr_o,
  output logic pc_load_o,
  output logic [15:0] pc_value_o,
  output logic in_service_o,
  output logic [3:0] taken_src_o
);
  typedef struct packed {
    logic [3:0] pre;
    logic [15:0] count;
    logic wrap;
    logic [2:0] capf;
    ico_pkg::ico_seq_state_t state;
    logic [3:0] stk;
    logic [3:0] pick;
    logic [15:0] addr;
    logic [7:0] hi;
    logic [15:0] pc;
    logic pc_load;
    logic in_svc;
    logic [3:0] taken;
  } ico_top_state_t;

  ico_top_state_t st_q;
  ico_top_state_t st_d;
  logic [2:0] cap_ev;
  logic [3:0] req;
  logic tick;
  logic wrap_ev;
  logic take;
  logic ccr_slot;

  ico_insn_if insn_if ();

  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: pre_limit = ico_pkg::PRE_LIM_1;
      2'h1: pre_limit = ico_pkg::PRE_LIM_4;
      2'h2: pre_limit = ico_pkg::PRE_LIM_8;
      default: pre_limit = ico_pkg::PRE_LIM_16;
    endcase
  endfunction : pre_limit

  // Lowest index wins, so the wrap source is taken last
  function automatic logic [3:0] pick_src(input logic [3:0] r);
    if (r[0])
      pick_src = 4'h1;
    else if (r[1])
      pick_src = 4'h2;
    else if (r[2])
      pick_src = 4'h4;
    else
      pick_src = 4'h8;
  endfunction : pick_src

  function automatic logic [15:0] vec_of(input logic [3:0] p);
    if (p[0])
      vec_of = ico_pkg::VEC_CAP1;
    else if (p[1])
      vec_of = ico_pkg::VEC_CAP2;
    else if (p[2])
      vec_of = ico_pkg::VEC_CAP3;
    else
      vec_of = ico_pkg::VEC_WRAP;
  endfunction : vec_of

  genvar g;
  generate
    for (g = 0; g < ico_pkg::NUM_CAP; g++)
    begin : g_cap
      ico_capture u_cap (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(cap_pin_i[g]),
        .mode_i(cap_mode_i[2*g+1:2*g]),
        .count_i(st_q.count),
        .value_o(cap_value_o[16*g+15:16*g]),
        .event_o(cap_ev[g])
      );
    end
  endgenerate

  ico_insn_timer u_insn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(insn_start_i),
    .len_i(insn_len_i),
    .multiply_opcode_i(multiply_opcode_i),
    .insn_if(insn_if)
  );

  assign req = {st_q.wrap & irq_en_i[3], st_q.capf & irq_en_i[2:0]};
  // Flags are registered, so a late edge in the last cycle misses this boundary
  assign take = insn_if.boundary && (|req) && !st_q.in_svc; // see R4, R9
  assign insn_if.hold = (st_q.state != ico_pkg::SEQ_RUN) || take;
  assign ccr_slot = (st_q.state == ico_pkg::SEQ_STACK) && (st_q.stk == 4'(ico_pkg::STACK_BYTES - 4'h1));

  always_comb
  begin
    st_d = st_q;
    st_d.pc_load = 1'b0;
    st_d.taken = 4'h0;
    tick = st_q.pre >= pre_limit(prescale_sel_i); // see R10
    st_d.pre = tick ? 4'h0 : 4'(st_q.pre + 4'h1);
    wrap_ev = tick && (st_q.count == ico_pkg::COUNT_MAX);
    if (tick)
    begin
      st_d.count = 16'(st_q.count + 16'h0001); // see R1
    end
    if (flag_clr_we_i)
    begin
      st_d.capf = st_q.capf & ~flag_clr_data_i[2:0]; // see R14
      st_d.wrap = st_q.wrap & ~flag_clr_data_i[3];
    end
    // Set after clear so an event in the clearing cycle is kept
    st_d.capf = st_d.capf | cap_ev; // see R3
    if (wrap_ev)
    begin
      st_d.wrap = 1'b1; // see R1
    end
    if (rti_i)
    begin
      st_d.in_svc = 1'b0; // see R9
    end
    case (st_q.state)
      ico_pkg::SEQ_RUN:
      begin
        if (take)
        begin
          st_d.state = ico_pkg::SEQ_STACK;
          st_d.stk = 4'h0;
        end
      end
      ico_pkg::SEQ_STACK:
      begin
        st_d.stk = 4'(st_q.stk + 4'h1);
        if (ccr_slot)
        begin
          // Requests seen up to the flags byte take part in the choice
          st_d.pick = pick_src(req); // see R5, R6, R8
          st_d.addr = vec_of(pick_src(req)); // see R13
          st_d.state = ico_pkg::SEQ_VEC_HI;
        end
      end
      ico_pkg::SEQ_VEC_HI:
      begin
        st_d.addr = 16'(st_q.addr + 16'h0001);
        st_d.state = ico_pkg::SEQ_VEC_LO;
      end
      ico_pkg::SEQ_VEC_LO:
      begin
        st_d.hi = vec_data_i;
        st_d.state = ico_pkg::SEQ_JUMP;
      end
      ico_pkg::SEQ_JUMP:
      begin
        st_d.pc = {st_q.hi, vec_data_i}; // see R12
        st_d.pc_load = 1'b1;
        st_d.in_svc = 1'b1;
        st_d.taken = st_q.pick;
        st_d.state = ico_pkg::SEQ_RUN;
      end
      default:
      begin
        st_d.state = ico_pkg::SEQ_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
      st_q.count <= ico_pkg::COUNT_RST;
      st_q.state <= ico_pkg::SEQ_RUN;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign count_o = st_q.count;
  assign capture_event_flag_o = st_q.capf;
  assign counter_wrap_flag_o = st_q.wrap;
  assign insn_boundary_o = insn_if.boundary;
  assign cpu_hold_o = insn_if.hold;
  assign stack_wr_o = st_q.state == ico_pkg::SEQ_STACK;
  assign stack_cond_flags_o = ccr_slot;
  assign vec_rd_o = (st_q.state == ico_pkg::SEQ_VEC_HI) || (st_q.state == ico_pkg::SEQ_VEC_LO);
  assign vec_addr_o = st_q.addr;
  assign pc_load_o = st_q.pc_load;
  assign pc_value_o = st_q.pc;
  assign in_service_o = st_q.in_svc;
  assign taken_src_o = st_q.taken;

  sequence s_fetch;
    vec_rd_o ##1 vec_rd_o ##1 !vec_rd_o ##1 pc_load_o;
  endsequence

  a_counter_step: // see R10
  assert property (@(posedge clk_i) disable iff (rst_i)
    // The first edge out of reset still shows the reset count, so it is left out
    !$past(rst_i) && prescale_sel_i == 2'h0 && $past(prescale_sel_i) == 2'h0
    && $past(st_q.pre) == 4'h0
    |-> count_o == 16'($past(count_o) + 16'h0001))
  else $error("counter did not advance each cycle at prescale one");

  a_wrap_flag: // see R1
  assert property (@(posedge clk_i) disable iff (rst_i)
    wrap_ev |=> counter_wrap_flag_o && count_o == ico_pkg::COUNT_RST)
  else $error("wrap flag not set on rollover");

  a_w1c_keeps: // see R14
  assert property (@(posedge clk_i) disable iff (rst_i)
    flag_clr_we_i && !flag_clr_data_i[0] && capture_event_flag_o[0]
    |=> capture_event_flag_o[0])
  else $error("writing zero cleared a flag");

  a_set_wins: // see R3
  assert property (@(posedge clk_i) disable iff (rst_i)
    cap_ev[1] && flag_clr_we_i && flag_clr_data_i[1] |=> capture_event_flag_o[1])
  else $error("edge lost in clearing cycle");

  a_take_boundary: // see R4
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(stack_wr_o) |-> $past(insn_if.boundary) && !$past(in_service_o))
  else $error("stacking began off a boundary or during service");

  a_vector_after: // see R5
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(vec_rd_o) |-> $past(stack_cond_flags_o))
  else $error("vector fetch not right after stacking");

  a_first_prio: // see R6
  assert property (@(posedge clk_i) disable iff (rst_i)
    stack_cond_flags_o && req[0] |=> vec_addr_o == ico_pkg::VEC_CAP1)
  else $error("first capture pending at flags byte not vectored");

  a_wrap_lowest: // see R8
  assert property (@(posedge clk_i) disable iff (rst_i)
    stack_cond_flags_o && (|req[2:0]) |=> vec_addr_o != ico_pkg::VEC_WRAP)
  else $error("wrap vectored ahead of a capture");

  a_jump_direct: // see R12
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(vec_rd_o) |-> s_fetch ##0 pc_value_o[7:0] == $past(vec_data_i))
  else $error("vector fetch did not load the address");

  a_service_block: // see R9
  assert property (@(posedge clk_i) disable iff (rst_i)
    in_service_o && !rti_i |=> !$rose(stack_wr_o))
  else $error("request taken during service");

  a_vector_pair: // see R13
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(vec_rd_o) |=> vec_rd_o && vec_addr_o == 16'($past(vec_addr_o) + 16'h0001))
  else $error("low vector byte not read from the next address");

  a_pc_pulse: // see R12
  assert property (@(posedge clk_i) disable iff (rst_i)
    pc_load_o |=> !pc_load_o && in_service_o)
  else $error("jump pulse longer than one cycle or service not entered");
endmodule : ico_top
`default_nettype wire

// File: test/ico_pulse_src.sv
/*
  Far-side model: pulse source on the capture pins plus the vector bytes.
  Assumes the bench calls set_pin and that reads follow the bus clock.
*/
`default_nettype none
module ico_pulse_src (
  input wire logic clk_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  output logic [2:0] pin_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 3'h0;
  initial data_o = 8'h00;
  // Byte follows the read by one cycle; otherwise a changing pattern, never a stale byte
  always @(posedge clk_i)
    data_o <= vec_rd_i ? (vec_addr_i[7:0] ^ 8'ha5) : ~data_o;
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk_i);
    pin_o[ch] <= v;
  endtask : set_pin
endmodule : ico_pulse_src
`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench of the capture timer and its interrupt sequencer.
  Assumes the pulse source model; prescale stays at divide by one.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] mode = 6'h00;
  logic clr_we = 1'b0;
  logic [3:0] clr_d = 4'h0;
  logic [3:0] en = 4'h0;
  logic start = 1'b0;
  logic [3:0] len = 4'h1;
  logic mul = 1'b0;
  logic rti = 1'b0;
  logic busy = 1'b0;
  logic run = 1'b0;
  logic go = 1'b0;
  logic bnd_p = 1'b0;
  logic stk_p = 1'b0;
  logic [47:0] capv_p = 48'h0;
  logic [2:0] pins, cflag;
  logic [7:0] vdat;
  logic [15:0] count, vaddr, pcv;
  logic [47:0] capv;
  logic wflag, bnd, hold, stk, cflg, vrd, pcl, insv;
  logic [3:0] src;
  logic [31:0] t;
  logic [19:0] e;
  int ncyc = 0;
  int seed = 32'h4b3a;
  int err_count = 0;
  int n_compared = 0;
  int nstk = 0;
  int nvrd = 0;
  logic [19:0] cap_q[3][$];
  logic [19:0] bnd_q[$];
  logic [19:0] irq_q[$];
  logic [15:0] vtab[4] = '{ico_pkg::VEC_CAP1, ico_pkg::VEC_CAP2, ico_pkg::VEC_CAP3,
    ico_pkg::VEC_WRAP};

  ico_pulse_src ico_pulse_src_i (.clk_i(clk_i), .vec_rd_i(vrd), .vec_addr_i(vaddr),
    .pin_o(pins), .data_o(vdat));
  ico_top ico_top_i (.clk_i(clk_i), .rst_i(rst_i), .cap_pin_i(pins), .cap_mode_i(mode),
    .prescale_sel_i(2'h0), .flag_clr_we_i(clr_we), .flag_clr_data_i(clr_d),
    .irq_en_i(en), .insn_start_i(start), .insn_len_i(len), .multiply_opcode_i(mul),
    .rti_i(rti), .vec_data_i(vdat), .count_o(count), .cap_value_o(capv),
    .capture_event_flag_o(cflag), .counter_wrap_flag_o(wflag), .insn_boundary_o(bnd),
    .cpu_hold_o(hold), .stack_wr_o(stk), .stack_cond_flags_o(cflg), .vec_rd_o(vrd),
    .vec_addr_o(vaddr), .pc_load_o(pcl), .pc_value_o(pcv), .in_service_o(insv),
    .taken_src_o(src));

  always #25 clk_i = ~clk_i;

  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (exp !== got)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Value is the count two cycles after the pin change, past the synchroniser
  task automatic pin(input int c, input logic v, input logic cap);
    ico_pulse_src_i.set_pin(c, v);
    if (cap)
      cap_q[c].push_back(20'(16'(ncyc[15:0] + 16'h3)));
  endtask : pin

  task automatic clr(input logic [3:0] m);
    @(posedge clk_i);
    clr_we <= 1'b1;
    clr_d <= m;
    @(posedge clk_i);
    clr_we <= 1'b0;
  endtask : clr

  task automatic ret(input logic [3:0] m);
    clr(m);
    rti <= 1'b1;
    @(posedge clk_i);
    rti <= 1'b0;
  endtask : ret

  task automatic exp_irq(input int i);
    logic [15:0] v;
    v = vtab[i];
    irq_q.push_back({4'h1 << i, v[7:0] ^ 8'ha5, (v[7:0] + 8'h01) ^ 8'ha5});
  endtask : exp_irq

  task automatic wait_irq;
    for (int i = 0; i < 400 && irq_q.size() != 0; i++)
      @(posedge clk_i);
    check("irq pending", 20'h0, 20'(irq_q.size()));
  endtask : wait_irq

  // Instruction stream keeps boundaries coming; without them no request is ever taken
  always @(posedge clk_i)
  begin
    if (bnd)
      busy = 1'b0;
    // start is assigned go on every edge, so the pulse drops by itself
    go = run && !busy && !start && !hold;
    start <= go;
    if (go)
    begin
      t = $random(seed);
      mul <= t[1:0] == 2'h0;
      len <= {1'b0, t[4:2]} + 4'h1;
      start <= 1'b1;
      busy = 1'b1;
      bnd_q.push_back(20'(ncyc + 1 + ((t[1:0] == 2'h0) ? 10 : t[4:2] + 1)));
    end
  end

  always @(posedge clk_i)
  begin
    capv_p <= capv;
    bnd_p <= bnd;
    stk_p <= stk;
    if (!rst_i)
    begin
      ncyc <= ncyc + 1;
      if (bnd)
      begin
        e = bnd_q.size() != 0 ? bnd_q.pop_front() : 20'hfffff;
        check("boundary", e, ncyc[19:0]);
      end
      for (int c = 0; c < 3; c++)
        if (capv[16 * c +: 16] !== capv_p[16 * c +: 16])
        begin
          e = cap_q[c].size() != 0 ? cap_q[c].pop_front() : 20'hfffff;
          check("capture", e, {4'h0, capv[16 * c +: 16]});
        end
      if (stk && !stk_p)
        check("take", 20'h1, {19'h0, bnd_p});
      if (stk)
      begin
        check("stack in service", 20'h0, {19'h0, insv});
        check("flags byte", {19'h0, nstk == 8}, {19'h0, cflg});
        nstk++;
      end
      if (vrd)
        nvrd++;
      if (pcl)
      begin
        check("stack len", 20'h9, 20'(nstk));
        check("vec reads", 20'h2, 20'(nvrd));
        e = irq_q.size() != 0 ? irq_q.pop_front() : 20'hfffff;
        check("vector", e, {src, pcv});
        nstk = 0;
        nvrd = 0;
      end
      if (ncyc > 80000)
      begin
        err_count++;
        give_verdict();
      end
    end
  end

  initial
  begin
    tick(20);
    rst_i <= 1'b0;
    run <= 1'b1;
    tick(8);
    check("count", ncyc[19:0], {4'h0, count});
    mode <= 6'h39;
    for (int k = 0; k < 4; k++)
      for (int c = 0; c < 3; c++)
      begin
        pin(c, !k[0], k[0] ? c != 0 : c != 1);
        tick(6 + ($random(seed) & 7));
      end
    check("flags", 20'h7, {17'h0, cflag});
    clr(4'h5);
    tick(1);
    check("flags", 20'h2, {17'h0, cflag});
    clr(4'ha);
    tick(1);
    check("flags", 20'h0, {17'h0, cflag});
    mode <= 6'h00;
    for (int k = 0; k < 6; k++)
      pin(k % 3, k < 3, 1'b0);
    tick(8);
    mode <= 6'h15;
    en <= 4'h7;
    exp_irq(1);
    pin(1, 1'b1, 1'b1);
    wait_irq();
    pin(0, 1'b1, 1'b1);
    tick(30);
    exp_irq(0);
    ret(4'h2);
    wait_irq();
    ret(4'h1);
    pin(0, 1'b0, 1'b0);
    pin(1, 1'b0, 1'b0);
    tick(6);
    en <= 4'h5;
    exp_irq(0);
    pin(2, 1'b1, 1'b1);
    for (int i = 0; i < 100 && !stk; i++)
      @(posedge clk_i);
    pin(0, 1'b1, 1'b1);
    wait_irq();
    exp_irq(2);
    ret(4'h1);
    wait_irq();
    ret(4'h4);
    en <= 4'h0;
    // Capture shortly before the wrap, so both flags are pending with the top bit set
    while (ncyc != 65520)
      @(posedge clk_i);
    pin(1, 1'b1, 1'b1);
    while (ncyc != 65536)
      @(posedge clk_i);
    check("capture msb", 20'h1, {19'h0, capv[31]});
    check("wrap count", 20'h0, {4'h0, count});
    check("wrap flag", 20'h1, {19'h0, wflag});
    en <= 4'ha;
    exp_irq(1);
    wait_irq();
    exp_irq(3);
    ret(4'h2);
    wait_irq();
    ret(4'h8);
    tick(20);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
